/* File: logic/ssm_pkg.sv */
// Shared types and constants for the quality message timing block
package ssm_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Delay windows in ms, defaults at the midpoint
  // ****************************************************************
  localparam int HM_MIN_MS  = 500;
  localparam int HM_MAX_MS  = 2000;
  localparam int NSM_MIN_MS = 1;
  localparam int NSM_MAX_MS = 199;
  localparam int SM_MIN_MS  = 180;
  localparam int SM_MAX_MS  = 500;
  localparam int HM_DEF_MS  = (HM_MIN_MS + HM_MAX_MS) / 2;
  localparam int NSM_DEF_MS = (NSM_MIN_MS + NSM_MAX_MS) / 2;
  localparam int SM_DEF_MS  = (SM_MIN_MS + SM_MAX_MS) / 2;
  localparam int MS_W       = 12;

  // ****************************************************************
  // Sizes and quality codes
  // ****************************************************************
  localparam int NPORT = 4;
  localparam int IDX_W = 2;

  typedef logic [4:0] ssm_ql_t;
  typedef logic [3:0] ssm_clock_source_identifier_t;
  typedef logic [2:0] ssm_prio_t;

  localparam ssm_ql_t QL_PRC    = 5'h02;
  localparam ssm_ql_t QL_SSUT   = 5'h04;
  localparam ssm_ql_t QL_SSUL   = 5'h08;
  localparam ssm_ql_t QL_SEC    = 5'h0B;
  localparam ssm_ql_t QUALITY_DO_NOT_USE    = 5'h0F;
  localparam ssm_ql_t QL_NSUPP  = 5'h10;
  localparam ssm_ql_t QL_FAILED = 5'h12;
  localparam ssm_ql_t QL_HOLD   = QL_SEC;
  localparam ssm_ql_t QL_RST    = QUALITY_DO_NOT_USE;
  localparam ssm_clock_source_identifier_t CLOCK_SOURCE_IDENTIFIER_NONE = 4'h0;

  // ****************************************************************
  // Bundles and event kinds
  // ****************************************************************
  typedef struct packed {
    logic      ck;
    logic      server_fail;
    ssm_ql_t   ql;
    ssm_clock_source_identifier_t clock_source_identifier;
  } ssm_cp_s;

  typedef struct packed {
    logic      ck;
    logic      trail_fail;
    ssm_ql_t   ql;
    ssm_clock_source_identifier_t clock_source_identifier;
  } ssm_ap_s;

  typedef enum logic [1:0] {
    EV_NONE = 2'b00,
    EV_HOLD = 2'b01,
    EV_QL   = 2'b10,
    EV_SW   = 2'b11
  } ssm_ev_e;

endpackage

/* File: logic/ssm_delay.sv */
// Millisecond tick and restartable delay countdown
module ssm_delay #(
  parameter int TICK_CYCLES = ssm_pkg::TICK_CYCLES
) (
  input  wire logic                    mclk,     // System clock
  input  wire logic                    rst,      // Sync reset, high
  input  wire logic                    load,     // Restart with new delay
  input  wire logic [ssm_pkg::MS_W-1:0] delay_ms, // Delay in ms, nonzero
  output logic                         done,     // Pulse at expiry
  output logic                         busy      // Countdown running
);

  logic [31:0]              pre_r;
  logic [ssm_pkg::MS_W-1:0] left_r;
  logic                     tick;

  // Prescaler restarts on load so the delay is exact, not +-1 ms
  assign tick = busy && (pre_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge mclk)
  begin
    if (rst || load || tick)
      pre_r <= 32'h0000_0000;
    else if (busy)
      pre_r <= pre_r + 32'h0000_0001;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      left_r <= '0;
    else if (load)
      left_r <= delay_ms;
    else if (tick)
      left_r <= left_r - 1'b1;
  end

  assign busy = (left_r != '0);
  assign done = tick && (left_r == {{(ssm_pkg::MS_W-1){1'b0}}, 1'b1}) &&
                !load;

endmodule

/* File: logic/ssm_timing.sv */
// Reference selection, holdover and outgoing quality message timing
// Function
// - Lose the only usable reference: enter holdover immediately.
// - Holdover code goes out 500 to 2000 ms after holdover entry.
// - Quality change without switch goes out in under 200 ms.
// - New source: message change applied 180 to 500 ms later.
// - Connection point bundle: clock, server fail, quality, source id.
// - Access point bundle: clock, trail fail, quality, source id.
// - Input without status messaging gets quality not supported.
// - Insert quality on transmit; send do-not-use or squelch for loops.
// - Pick best non-failed quality, then priority, keep current on tie.
// - Port whose own source id is selected sends do-not-use.
module ssm_timing #(
  parameter int TICK_CYCLES = ssm_pkg::TICK_CYCLES,
  parameter int HM_MS       = ssm_pkg::HM_DEF_MS,
  parameter int NSM_MS      = ssm_pkg::NSM_DEF_MS,
  parameter int SM_MS       = ssm_pkg::SM_DEF_MS
) (
  input  wire logic                              mclk,         // Clock
  input  wire logic                              rst,          // Reset
  input  wire ssm_pkg::ssm_cp_s [ssm_pkg::NPORT-1:0] in_cp,    // Inputs
  input  wire logic [ssm_pkg::NPORT-1:0]         ssm_support,  // Has msgs
  input  wire ssm_pkg::ssm_prio_t [ssm_pkg::NPORT-1:0] prio,   // 0 best
  input  wire logic                              squelch_mode, // Squelch
  output ssm_pkg::ssm_ap_s                       sel_ap,       // Selected
  output ssm_pkg::ssm_cp_s [ssm_pkg::NPORT-1:0]  out_cp,       // Tx ports
  output logic [ssm_pkg::NPORT-1:0]              out_squelch,  // Mute port
  output logic                                   holdover      // Holdover
);

  // ****************************************************************
  // Delay constants
  // ****************************************************************
  // clamp to window
  localparam int HM_C  = (HM_MS < ssm_pkg::HM_MIN_MS) ? ssm_pkg::HM_MIN_MS :
                         (HM_MS > ssm_pkg::HM_MAX_MS) ? ssm_pkg::HM_MAX_MS :
                         HM_MS;
  localparam int NSM_C = (NSM_MS < ssm_pkg::NSM_MIN_MS) ?
                         ssm_pkg::NSM_MIN_MS :
                         (NSM_MS > ssm_pkg::NSM_MAX_MS) ?
                         ssm_pkg::NSM_MAX_MS : NSM_MS;
  localparam int SM_C  = (SM_MS < ssm_pkg::SM_MIN_MS) ? ssm_pkg::SM_MIN_MS :
                         (SM_MS > ssm_pkg::SM_MAX_MS) ? ssm_pkg::SM_MAX_MS :
                         SM_MS;

  // ****************************************************************
  // Receive side quality
  // ****************************************************************
  ssm_pkg::ssm_ql_t [ssm_pkg::NPORT-1:0] eff_ql;
  logic [ssm_pkg::NPORT-1:0]             cand;

  for (genvar g = 0; g < ssm_pkg::NPORT; g++)
  begin : g_rx
    assign eff_ql[g] = !ssm_support[g] ? ssm_pkg::QL_NSUPP :
                       in_cp[g].server_fail ? ssm_pkg::QL_FAILED :
                       in_cp[g].ql;
    assign cand[g] = !in_cp[g].server_fail &&
                     (eff_ql[g] == ssm_pkg::QL_PRC ||
                      eff_ql[g] == ssm_pkg::QL_SSUT ||
                      eff_ql[g] == ssm_pkg::QL_SSUL ||
                      eff_ql[g] == ssm_pkg::QL_SEC);
  end

  // ****************************************************************
  // Selection
  // ****************************************************************
  logic [ssm_pkg::IDX_W-1:0] sel_r;
  logic                      have_r;
  ssm_pkg::ssm_ql_t          sel_ql_r;
  logic [ssm_pkg::IDX_W-1:0] best;
  logic                      found;
  ssm_pkg::ssm_ql_t          bq;
  ssm_pkg::ssm_prio_t        bp;

  always_comb
  begin
    found = have_r && cand[sel_r];
    best  = sel_r;
    bq    = eff_ql[sel_r];
    bp    = prio[sel_r];
    for (int i = 0; i < ssm_pkg::NPORT; i++)
    begin
      if (cand[i] && (!found || eff_ql[i] < bq ||
                      (eff_ql[i] == bq && prio[i] < bp)))
      begin
        found = 1'b1;
        best  = ssm_pkg::IDX_W'(i);
        bq    = eff_ql[i];
        bp    = prio[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_r    <= '0;
      have_r   <= 1'b0;
      sel_ql_r <= ssm_pkg::QL_RST;
    end
    else
    begin
      sel_r    <= best;
      have_r   <= found;
      sel_ql_r <= found ? bq : ssm_pkg::QL_HOLD;
    end
  end

  assign holdover = !have_r;

  // ****************************************************************
  // Message events and delay
  // ****************************************************************
  ssm_pkg::ssm_ev_e         ev;
  logic [ssm_pkg::MS_W-1:0] ev_ms;
  ssm_pkg::ssm_ql_t         pend_r;
  ssm_pkg::ssm_ql_t         msg_r;
  ssm_pkg::ssm_ev_e         kind_r;
  logic                     done;

  always_comb
  begin
    if (have_r && !found)
      ev = ssm_pkg::EV_HOLD;
    else if (found && (!have_r || best != sel_r))
      ev = ssm_pkg::EV_SW;
    else if (found && bq != sel_ql_r)
      ev = ssm_pkg::EV_QL;
    else
      ev = ssm_pkg::EV_NONE;
  end

  always_comb
  begin
    unique case (ev)
      ssm_pkg::EV_HOLD: ev_ms = ssm_pkg::MS_W'(HM_C);
      ssm_pkg::EV_QL:   ev_ms = ssm_pkg::MS_W'(NSM_C);
      ssm_pkg::EV_SW:   ev_ms = ssm_pkg::MS_W'(SM_C);
      ssm_pkg::EV_NONE: ev_ms = ssm_pkg::MS_W'(SM_C);
    endcase
  end

  ssm_delay #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_delay (
    .mclk     (mclk),
    .rst      (rst),
    .load     (ev != ssm_pkg::EV_NONE),
    .delay_ms (ev_ms),
    .done     (done),
    .busy     ()
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pend_r <= ssm_pkg::QL_RST;
      kind_r <= ssm_pkg::EV_NONE;
    end
    else if (ev != ssm_pkg::EV_NONE)
    begin
      pend_r <= found ? bq : ssm_pkg::QL_HOLD;
      kind_r <= ev;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      msg_r <= ssm_pkg::QL_RST;
    else if (done)
      msg_r <= pend_r;
  end

  // ****************************************************************
  // Bundles and transmit side
  // ****************************************************************
  ssm_pkg::ssm_clock_source_identifier_t sel_clock_source_identifier;
  assign sel_clock_source_identifier = have_r ? in_cp[sel_r].clock_source_identifier :
                    ssm_pkg::CLOCK_SOURCE_IDENTIFIER_NONE;

  assign sel_ap = '{ck: have_r && in_cp[sel_r].ck, trail_fail: !have_r,
                    ql: msg_r, clock_source_identifier: sel_clock_source_identifier};

  for (genvar g = 0; g < ssm_pkg::NPORT; g++)
  begin : g_tx
    logic loop_w;
    assign loop_w = have_r && sel_r == ssm_pkg::IDX_W'(g);
    // insert quality
    // Holdover runs on the local oscillator, shown as a steady high
    assign out_cp[g] = '{ck: holdover || in_cp[sel_r].ck, server_fail: 1'b0,
                         ql: loop_w ? ssm_pkg::QUALITY_DO_NOT_USE : msg_r,
                         clock_source_identifier: sel_clock_source_identifier};
    assign out_squelch[g] = loop_w && squelch_mode;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [31:0] elap_r;
  always_ff @(posedge mclk)
  begin
    if (rst || ev != ssm_pkg::EV_NONE)
      elap_r <= 32'h0000_0000;
    else if (elap_r != 32'hFFFF_FFFF)
      elap_r <= elap_r + 32'h0000_0001;
  end

  sequence s_lost;
    have_r && !found;
  endsequence
  property p_hold_now;
    @(posedge mclk) disable iff (rst) s_lost |=> holdover;
  endproperty
  a_hold_now: assert property (p_hold_now)
    else $error("holdover not entered at once");

  property p_hm_time;
    @(posedge mclk) disable iff (rst) done && kind_r == ssm_pkg::EV_HOLD
      |-> elap_r == 32'(HM_C * TICK_CYCLES - 1);
  endproperty
  a_hm_time: assert property (p_hm_time)
    else $error("holdover message delay wrong");

  property p_nsm_time;
    @(posedge mclk) disable iff (rst) done && kind_r == ssm_pkg::EV_QL
      |-> elap_r < 32'(ssm_pkg::NSM_MAX_MS * TICK_CYCLES + 1);
  endproperty
  a_nsm_time: assert property (p_nsm_time)
    else $error("non switching delay too long");

  property p_sm_time;
    @(posedge mclk) disable iff (rst) done && kind_r == ssm_pkg::EV_SW
      |-> elap_r == 32'(SM_C * TICK_CYCLES - 1);
  endproperty
  a_sm_time: assert property (p_sm_time)
    else $error("switch message delay wrong");

  property p_msg_apply;
    @(posedge mclk) disable iff (rst) done |=> msg_r == $past(pend_r);
  endproperty
  a_msg_apply: assert property (p_msg_apply)
    else $error("pending message not applied");

  property p_nsupp;
    @(posedge mclk) disable iff (rst)
      !ssm_support[0] |-> !cand[0] && eff_ql[0] != in_cp[0].ql ||
      in_cp[0].ql == ssm_pkg::QL_NSUPP;
  endproperty
  a_nsupp: assert property (p_nsupp)
    else $error("unsupported input selectable");

  property p_sel_ok;
    @(posedge mclk) disable iff (rst)
      have_r |-> $past(cand[best]) || $past(rst);
  endproperty
  a_sel_ok: assert property (p_sel_ok)
    else $error("failed input selected");

  property p_loop_dnu;
    @(posedge mclk) disable iff (rst)
      have_r |-> out_cp[sel_r].ql == ssm_pkg::QUALITY_DO_NOT_USE &&
      sel_ap.clock_source_identifier == in_cp[sel_r].clock_source_identifier;
  endproperty
  a_loop_dnu: assert property (p_loop_dnu)
    else $error("loop port not do-not-use");

endmodule

/* File: bench/ssm_peer.sv */
// Downstream clock model that listens to each transmit port
module ssm_peer
(
  input  wire logic                                  mclk,  // Clock
  input  wire logic                                  rst,   // Reset
  input  wire ssm_pkg::ssm_cp_s [ssm_pkg::NPORT-1:0] tx_cp, // From device
  input  wire logic [ssm_pkg::NPORT-1:0]             mute,  // Squelched
  output ssm_pkg::ssm_ql_t [ssm_pkg::NPORT-1:0]      rx_ql  // Heard quality
);
  // ************************************************
  // Receive side
  // ************************************************
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < ssm_pkg::NPORT; i++)
    begin
      if (rst || mute[i] || tx_cp[i].server_fail)
        rx_ql[i] <= ssm_pkg::QL_FAILED;
      else
        rx_ql[i] <= tx_cp[i].ql;
    end
  end
endmodule

/* File: bench/test_sync_status_message_timing.sv */
// Self-checking bench for the quality message timing block
module test_sync_status_message_timing;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps the long delays affordable
  localparam int TK = 10;
  logic                          mclk;
  logic                          rst;
  logic                          squelch_mode;
  logic [3:0]                    ssm_support;
  logic [3:0]                    out_squelch;
  logic                          holdover;
  ssm_pkg::ssm_cp_s [3:0]        in_cp;
  ssm_pkg::ssm_cp_s [3:0]        out_cp;
  ssm_pkg::ssm_prio_t [3:0]      prio;
  ssm_pkg::ssm_ap_s              sel_ap;
  ssm_pkg::ssm_ql_t [3:0]        rx_ql;
  int                            error_cnt;
  int                            checked;
  typedef ssm_pkg::ssm_ql_t ssm_row_t [4];
  ssm_row_t rows = '{ssm_pkg::QL_SSUT, ssm_pkg::QL_PRC, ssm_pkg::QL_SEC,
                     ssm_pkg::QL_SSUL};

  ssm_timing #(.TICK_CYCLES(TK)) i_dut (.mclk(mclk), .rst(rst),
    .in_cp(in_cp), .ssm_support(ssm_support), .prio(prio),
    .squelch_mode(squelch_mode), .sel_ap(sel_ap), .out_cp(out_cp),
    .out_squelch(out_squelch), .holdover(holdover));
  ssm_peer i_peer (.mclk(mclk), .rst(rst), .tx_cp(out_cp),
    .mute(out_squelch), .rx_ql(rx_ql));

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (!ok)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic drv(input int i, input ssm_pkg::ssm_ql_t q, input logic f);
    in_cp[i].ql <= q;
    in_cp[i].server_fail <= f;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Counts edges until q shows; window in ms
  task automatic wait_ql(input ssm_pkg::ssm_ql_t q, input int lo,
                         input int hi);
    int n;
    n = 0;
    while (sel_ap.ql !== q && n <= hi * TK + 4)
    begin
      step(1);
      n++;
    end
    chk(n >= lo * TK && n <= hi * TK + 2, "message timing");
    if (n > hi * TK + 4)
      test_done();
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    squelch_mode = 1'b0;
    ssm_support = 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      in_cp[i].ck = 1'b1;
      in_cp[i].server_fail = 1'b1;
      in_cp[i].ql = ssm_pkg::QL_FAILED;
      in_cp[i].clock_source_identifier = ssm_pkg::ssm_clock_source_identifier_t'(i + 1);
      prio[i] = ssm_pkg::ssm_prio_t'(i);
    end
    step(16);
    rst <= 1'b0;
    step(1);
    chk(holdover === 1'b1 && sel_ap.ql === ssm_pkg::QUALITY_DO_NOT_USE, "reset");
    @(posedge mclk);
    drv(0, ssm_pkg::QL_SSUL, 1'b0);
    wait_ql(ssm_pkg::QL_SSUL, ssm_pkg::SM_MIN_MS, ssm_pkg::SM_MAX_MS);
    chk(holdover === 1'b0 && sel_ap.trail_fail === 1'b0, "lock");
    chk(sel_ap.clock_source_identifier === 4'h1, "selected id");
    chk(out_cp[0].ql === ssm_pkg::QUALITY_DO_NOT_USE, "loop port");
    chk(out_cp[1].clock_source_identifier === 4'h1, "port id");
    step(1);
    chk(rx_ql[1] === ssm_pkg::QL_SSUL, "peer quality");
    $display("done: first lock");
    foreach (rows[r])
    begin
      @(posedge mclk);
      drv(0, rows[r], 1'b0);
      wait_ql(rows[r], 0, ssm_pkg::NSM_MAX_MS);
      chk(out_cp[2].ql === rows[r], "port quality");
    end
    $display("done: quality rows");
    @(posedge mclk);
    squelch_mode <= 1'b1;
    drv(1, ssm_pkg::QL_PRC, 1'b0);
    wait_ql(ssm_pkg::QL_PRC, ssm_pkg::SM_MIN_MS, ssm_pkg::SM_MAX_MS);
    chk(sel_ap.clock_source_identifier === 4'h2, "better source");
    chk(out_squelch === 4'b0010, "squelch");
    step(1);
    chk(rx_ql[1] === ssm_pkg::QL_FAILED && rx_ql[0] === ssm_pkg::QL_PRC,
        "peer view");
    @(posedge mclk);
    prio[2] <= 3'h1;
    drv(2, ssm_pkg::QL_PRC, 1'b0);
    step(5);
    chk(sel_ap.clock_source_identifier === 4'h2, "tie kept");
    @(posedge mclk);
    prio[2] <= 3'h0;
    step(3);
    chk(sel_ap.clock_source_identifier === 4'h3, "priority");
    $display("done: selection");
    @(posedge mclk);
    drv(0, ssm_pkg::QL_FAILED, 1'b1);
    drv(1, ssm_pkg::QL_FAILED, 1'b1);
    step(10);
    @(posedge mclk);
    drv(2, ssm_pkg::QL_SSUT, 1'b0);
    step(50 * TK);
    @(posedge mclk);
    drv(2, ssm_pkg::QL_SSUL, 1'b0);
    step(60 * TK);
    chk(sel_ap.ql === ssm_pkg::QL_PRC, "restart");
    wait_ql(ssm_pkg::QL_SSUL, 0, ssm_pkg::NSM_MAX_MS);
    $display("done: restart");
    @(posedge mclk);
    drv(2, ssm_pkg::QL_FAILED, 1'b1);
    step(2);
    chk(holdover === 1'b1 && sel_ap.trail_fail === 1'b1, "hold");
    chk(sel_ap.clock_source_identifier === ssm_pkg::CLOCK_SOURCE_IDENTIFIER_NONE, "none");
    @(posedge mclk);
    ssm_support[1] <= 1'b0;
    drv(1, ssm_pkg::QL_PRC, 1'b0);
    step(5);
    chk(holdover === 1'b1, "no messaging");
    wait_ql(ssm_pkg::QL_HOLD, ssm_pkg::HM_MIN_MS, ssm_pkg::HM_MAX_MS);
    $display("done: holdover");
    test_done();
  end
endmodule
